//--- logic/rqgt_pkg.sv
// Constants and types for the local bus request/grant handover
// Function
// - Hand the bus to another master only after the current bus cycle ends.
// - With requests on both pins, serve the high priority pin first.
// - An unconnected pin floats high, so it never shows a request.
// - Grant is a one-clock low pulse on that pin, then float and hold.
// - In hold the bus interface stays disconnected until the release pulse.
// - Third pulse ends hold; the bus is retaken at the next clock.
// - Three pulses per exchange, at least one idle clock after each exchange.
// - During a memory cycle, release at its final state if asked by state two.
// - Never release between the two byte accesses of a word operand.
// - Never release between the two interrupt acknowledge cycles.
// - With the bus idle, release during the next clock.
// - Idle but a cycle starts within three clocks: treat as asked early.
// - Float the lock output while in hold.
package rqgt_pkg;

    // Bus state codes reported by the bus interface
    localparam logic [2:0] BST_IDLE = 3'h0;
    localparam logic [2:0] BST_ONE = 3'h1;
    localparam logic [2:0] BST_TWO = 3'h2;
    localparam logic [2:0] BST_THREE = 3'h3;
    localparam logic [2:0] BST_WAIT = 3'h4;
    localparam logic [2:0] BST_FINAL = 3'h5;

    // Idle clocks required after an exchange
    localparam logic [1:0] IDLE_GAP = 2'h1;

    // Arbiter states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PENDING = 3'b001,
        ST_GRANT = 3'b010,
        ST_HOLD = 3'b011,
        ST_RETAKE = 3'b100,
        ST_GAP = 3'b101
    } arb_state_e;

endpackage

//--- logic/rqgt_pin.sv
// One request/grant pin: pulse detection and open-drain drive
`timescale 1ns/1ps
module rqgt_pin
    import rqgt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    // Pin
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    // Core side
    input wire logic drive_low,
    output logic low_seen
);
    logic last_level;

    // Unconnected pin reads high via the pull-up, so no edge ever
    assign low_seen = last_level & ~pin_in;
    assign pin_out = 1'b0;
    assign pin_oe = drive_low;

    always_ff @(posedge clk)
    begin
        if (rst)
            last_level <= 1'b1;
        else
            last_level <= pin_in;
    end
endmodule

//--- logic/local_bus_request_grant.sv
// Request/grant arbiter handing the local bus to other bus masters
`timescale 1ns/1ps
module local_bus_request_grant
    import rqgt_pkg::*;
(
    input wire logic MCLK_I,
    input wire logic RST_I,
    // High priority request/grant pin
    input wire logic RQGT_HI_I,
    output logic RQGT_HI_O,
    output logic RQGT_HI_OE_O,
    // Low priority request/grant pin
    input wire logic RQGT_LO_I,
    output logic RQGT_LO_O,
    output logic RQGT_LO_OE_O,
    // Bus interface status
    input wire logic [2:0] BUS_STATE_I,
    input wire logic MEM_CYCLE_I,
    input wire logic WORD_LOW_BYTE_I,
    input wire logic INTA_FIRST_I,
    input wire logic LOCKED_INSN_I,
    input wire logic MEM_SOON_I,
    input wire logic LOCK_REQ_I,
    // Bus control
    output logic BUS_FLOAT_O,
    output logic HOLD_ACK_O,
    output logic RETAKE_O,
    output logic LOCK_N_O,
    output logic LOCK_OE_O,
    output logic HOLDER_LO_O
);
    arb_state_e state;
    arb_state_e next_state;
    logic hi_seen;
    logic lo_seen;
    logic hi_drive;
    logic lo_drive;
    logic hi_wait;
    logic lo_wait;
    logic owner_lo;
    logic early;
    logic [1:0] gap_cnt;

    ////////////////////////////////////////////////////////////////////////
    // Pin handlers

    rqgt_pin u_hi (
        .clk(MCLK_I),
        .rst(RST_I),
        .pin_in(RQGT_HI_I),
        .pin_out(RQGT_HI_O),
        .pin_oe(RQGT_HI_OE_O),
        .drive_low(hi_drive),
        .low_seen(hi_seen)
    );

    rqgt_pin u_lo (
        .clk(MCLK_I),
        .rst(RST_I),
        .pin_in(RQGT_LO_I),
        .pin_out(RQGT_LO_O),
        .pin_oe(RQGT_LO_OE_O),
        .drive_low(lo_drive),
        .low_seen(lo_seen)
    );

    ////////////////////////////////////////////////////////////////////////
    // Release decision

    // Taken once the arbiter is free again; high pin wins a tie
    wire req_hi = hi_seen | hi_wait;
    wire req_lo = lo_seen | lo_wait;
    wire any_req = req_hi | req_lo;
    wire take_hi = (state == ST_IDLE) && req_hi;
    wire take_lo = (state == ST_IDLE) && req_lo && !req_hi;
    // Owner pin pulses in grant or hold are handshake, not requests
    wire between = (state == ST_RETAKE) || (state == ST_GAP);
    // A new request may come one idle clock after release
    wire park_hi = (state != ST_IDLE) && hi_seen &&
                   (owner_lo || between);
    wire park_lo = ((state == ST_IDLE) && req_lo && req_hi) ||
                   ((state != ST_IDLE) && lo_seen && (!owner_lo || between));
    // Request at or before state two counts as early
    wire req_early_now = (BUS_STATE_I == BST_ONE) ||
                         (BUS_STATE_I == BST_TWO);
    wire bus_idle = (BUS_STATE_I == BST_IDLE) && !MEM_CYCLE_I;
    // Cycle boundary is the final state of the running cycle
    wire at_final = (BUS_STATE_I == BST_FINAL);
    // Split word and interrupt acknowledge pairs stay together
    wire blocked = WORD_LOW_BYTE_I | INTA_FIRST_I | LOCKED_INSN_I;
    // Idle release next clock, unless a cycle is about to start
    wire idle_release = bus_idle && !MEM_SOON_I && !blocked;
    wire mem_release = at_final && early && !blocked;
    wire may_release = idle_release | mem_release;

    // Only the owner pin can end the hold
    wire release_pulse = owner_lo ? lo_seen : hi_seen;

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (any_req)
                    next_state = ST_PENDING;
            ST_PENDING:
                if (may_release)
                    next_state = ST_GRANT;
            ST_GRANT:
                next_state = ST_HOLD;
            ST_HOLD:
                if (release_pulse)
                    next_state = ST_RETAKE;
            ST_RETAKE:
                next_state = ST_GAP;
            ST_GAP:
                if (gap_cnt >= IDLE_GAP)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge MCLK_I)
    begin
        if (RST_I)
        begin
            state <= ST_IDLE;
            owner_lo <= 1'b0;
            early <= 1'b0;
            gap_cnt <= 2'h0;
        end
        else
        begin
            state <= next_state;
            if (state == ST_IDLE && any_req)
            begin
                owner_lo <= ~req_hi;
                // Pending cycle counts as already early
                early <= req_early_now | bus_idle;
            end
            gap_cnt <= (state == ST_GAP) ? gap_cnt + 2'h1 : 2'h0;
        end
    end

    // Losing pin parks its request; set and clear never share a cycle
    always_ff @(posedge MCLK_I)
    begin
        if (RST_I)
        begin
            hi_wait <= 1'b0;
            lo_wait <= 1'b0;
        end
        else
        begin
            hi_wait <= park_hi | (hi_wait & ~take_hi);
            lo_wait <= park_lo | (lo_wait & ~take_lo);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // One-clock grant pulse on the requesting pin
    assign hi_drive = (state == ST_GRANT) && !owner_lo;
    assign lo_drive = (state == ST_GRANT) && owner_lo;
    // Interface logically off the bus through hold
    assign HOLD_ACK_O = (state == ST_HOLD);
    assign BUS_FLOAT_O = (state == ST_HOLD);
    assign RETAKE_O = (state == ST_RETAKE);
    assign LOCK_N_O = ~LOCK_REQ_I;
    assign LOCK_OE_O = (state != ST_HOLD);
    assign HOLDER_LO_O = owner_lo;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence grant_seq;
        (state == ST_GRANT) ##1 (state == ST_HOLD);
    endsequence

    chk_grant_one_clock: assert property (@(posedge MCLK_I) disable iff (RST_I)
        $rose(RQGT_HI_OE_O | RQGT_LO_OE_O) |=> !(RQGT_HI_OE_O | RQGT_LO_OE_O))
        else $error("grant pulse wider than one clock");
    chk_hold_after_grant: assert property (@(posedge MCLK_I)
        disable iff (RST_I) (state == ST_GRANT) |=> HOLD_ACK_O && BUS_FLOAT_O)
        else $error("hold not entered after grant");
    chk_lock_floated: assert property (@(posedge MCLK_I) disable iff (RST_I)
        HOLD_ACK_O |-> !LOCK_OE_O)
        else $error("lock driven in hold");
    chk_no_split_word: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (state == ST_PENDING && (WORD_LOW_BYTE_I || INTA_FIRST_I
        || LOCKED_INSN_I)) |=> state != ST_GRANT)
        else $error("bus released mid operation");
    chk_retake_next: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (HOLD_ACK_O && release_pulse) |=> RETAKE_O ##1 !HOLD_ACK_O)
        else $error("bus not retaken after release");
    chk_gap_idle: assert property (@(posedge MCLK_I) disable iff (RST_I)
        RETAKE_O |=> (state == ST_GAP) ##1 (state == ST_GAP))
        else $error("no idle clock after exchange");
    chk_hi_first: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (state == ST_IDLE && hi_seen && lo_seen) |=> !owner_lo)
        else $error("low priority served first");
    chk_idle_release: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (state == ST_PENDING && idle_release) |=> grant_seq)
        else $error("idle bus not released at once");
    chk_late_request: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (state == ST_PENDING && at_final && !early) |=> state == ST_PENDING)
        else $error("late request released");
    chk_low_parked: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (state == ST_IDLE && req_hi && req_lo) |=> lo_wait)
        else $error("low priority request lost");
    chk_low_served: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (state == ST_IDLE && lo_wait && !req_hi) |=>
        (state == ST_PENDING && owner_lo))
        else $error("parked low request not served");
    chk_soon_waits: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (state == ST_PENDING && bus_idle && MEM_SOON_I) |=>
        state != ST_GRANT)
        else $error("bus released ahead of a starting cycle");
endmodule

//--- tb/rqgt_master.sv
// Model of another bus master asking for the bus on one pin
`timescale 1ns/1ps
module rqgt_master
(
    // Control
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic grant_i,
    // Pin pull-down
    output logic pull_low_o
);
    initial
    begin
        pull_low_o = 1'b0;
        forever
        begin
            @(posedge clk_i iff start_i);
            @(negedge clk_i);
            pull_low_o = 1'b1;
            @(negedge clk_i);
            pull_low_o = 1'b0;
            @(posedge clk_i iff grant_i);
            // Hold the bus a few clocks before handing it back
            repeat (4) @(negedge clk_i);
            pull_low_o = 1'b1;
            @(negedge clk_i);
            pull_low_o = 1'b0;
            repeat (3) @(negedge clk_i);
        end
    end
endmodule

//--- tb/local_bus_request_grant_test.sv
// Self-checking bench for the request/grant arbiter
`timescale 1ns/1ps
module local_bus_request_grant_test
    import rqgt_pkg::*;
;
    logic clk, rst, hi_o, hi_oe, lo_o, lo_oe, flt, hold, retake, lock_oe;
    logic holder_lo, mem, wlb, inta, lck, start_hi, start_lo, pull_hi, pull_lo;
    logic hi_i, lo_i, soon, lock_n;
    logic [2:0] bus_state;
    int errors = 0;
    int check_count = 0;
    // Open-drain wires with pull-up; unconnected pin stays high
    assign hi_i = ~((hi_oe & ~hi_o) | pull_hi);
    assign lo_i = ~((lo_oe & ~lo_o) | pull_lo);
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    local_bus_request_grant u_local_bus_request_grant (.MCLK_I(clk),
        .RST_I(rst), .RQGT_HI_I(hi_i), .RQGT_HI_O(hi_o), .RQGT_HI_OE_O(hi_oe),
        .RQGT_LO_I(lo_i), .RQGT_LO_O(lo_o), .RQGT_LO_OE_O(lo_oe),
        .BUS_STATE_I(bus_state), .MEM_CYCLE_I(mem), .WORD_LOW_BYTE_I(wlb),
        .INTA_FIRST_I(inta), .LOCKED_INSN_I(lck), .MEM_SOON_I(soon),
        .LOCK_REQ_I(lck), .BUS_FLOAT_O(flt), .HOLD_ACK_O(hold),
        .RETAKE_O(retake), .LOCK_N_O(lock_n), .LOCK_OE_O(lock_oe),
        .HOLDER_LO_O(holder_lo));
    rqgt_master u_rqgt_master_hi (.clk_i(clk), .start_i(start_hi),
        .grant_i(hi_oe), .pull_low_o(pull_hi));
    rqgt_master u_rqgt_master_lo (.clk_i(clk), .start_i(start_lo),
        .grant_i(lo_oe), .pull_low_o(pull_lo));
////////////////////////////////////////////////////////////////////////////
    task wrap_up;
        if (errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task check(input string s, input logic seen, input logic exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %b seen %b", s, exp, seen);
        end
    endtask
    task req_start(input logic h, input logic l);
        start_hi = h;
        start_lo = l;
        @(negedge clk);
        start_hi = 1'b0;
        start_lo = 1'b0;
    endtask
    // Bounded wait: sel 0 for a grant, 1 for retake
    task wait_for(input logic sel, output int n);
        n = 0;
        while ((sel ? retake : (hi_oe | lo_oe)) !== 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        check("handshake seen", n < 40, 1'b1);
    endtask
////////////////////////////////////////////////////////////////////////////
    task idle_handover;
        int n;
        req_start(1'b1, 1'b0);
        wait_for(1'b0, n);
        check("grant delay", n <= 3, 1'b1);
        check("low pin quiet", lo_oe, 1'b0);
        @(negedge clk);
        check("grant width", hi_oe, 1'b0);
        check("hold entered", hold, 1'b1);
        check("bus floated", flt, 1'b1);
        check("lock floated", lock_oe, 1'b0);
        wait_for(1'b1, n);
        check("hold kept", n >= 3, 1'b1);
        @(negedge clk);
        check("retake width", retake, 1'b0);
        check("hold left", hold, 1'b0);
        check("bus back", flt, 1'b0);
        check("lock driven again", lock_oe, 1'b1);
        repeat (4) @(negedge clk);
    endtask
    // Request lands in bus state first; -1 is idle with a cycle due
    // inh sets word, interrupt, lock inhibits
    task mem_run(input logic [2:0] inh, input int first,
        input logic [2:0] exp);
        logic [2:0] at;
        int n;
        at = 3'h7;
        {wlb, inta, lck} = inh;
        req_start(1'b1, 1'b0);
        check("lock pin", lock_n, ~inh[0]);
        for (int i = first; i < 10; i++)
        begin
            bus_state = (i > 0 && i < 6) ? 3'(i) : BST_IDLE;
            mem = (i > 0 && i < 6);
            soon = (i < 1);
            if (i == 6)
                {wlb, inta, lck} = 3'h0;
            @(negedge clk);
            if (hi_oe === 1'b1 && at === 3'h7)
                at = bus_state;
        end
        check("grant state", at === exp, 1'b1);
        wait_for(1'b1, n);
        repeat (4) @(negedge clk);
    endtask
    task both_pins;
        int n;
        req_start(1'b1, 1'b1);
        wait_for(1'b0, n);
        check("high pin first", hi_oe, 1'b1);
        check("low pin waits", lo_oe, 1'b0);
        @(negedge clk);
        check("holder", holder_lo, 1'b0);
        wait_for(1'b1, n);
        @(negedge clk);
        wait_for(1'b0, n);
        check("low pin served", lo_oe, 1'b1);
        check("high pin quiet", hi_oe, 1'b0);
        check("gap before low", n >= 3, 1'b1);
        @(negedge clk);
        check("low holder", holder_lo, 1'b1);
        check("low hold", hold, 1'b1);
        wait_for(1'b1, n);
        repeat (4) @(negedge clk);
    endtask
////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst, mem, wlb, inta, lck, start_hi, start_lo} = 7'h40;
        bus_state = BST_IDLE;
        soon = 1'b0;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        idle_handover();
        mem_run(3'h0, 2, BST_FINAL);
        mem_run(3'h4, 2, BST_IDLE);
        mem_run(3'h2, 2, BST_IDLE);
        mem_run(3'h1, 2, BST_IDLE);
        mem_run(3'h0, 3, BST_IDLE);
        mem_run(3'h0, -1, BST_FINAL);
        both_pins();
        wrap_up();
    end
    initial
    begin
        repeat (4000) @(posedge clk);
        errors++;
        wrap_up();
    end
endmodule
